//--- rsh_defines.svh
// Register offsets, field positions and reset values of the execution datapath
`ifndef RSH_DEFINES_SVH
`define RSH_DEFINES_SVH
`define RSH_ADDR_W      5
`define RSH_OFS_ACC     5'h00
`define RSH_OFS_STATUS  5'h04
`define RSH_OFS_CMD     5'h08
`define RSH_OFS_FADDR   5'h0C
`define RSH_OFS_FDATA   5'h10
`define RSH_OFS_WDOG    5'h14
`define RSH_ST_C        0
`define RSH_ST_DC       1
`define RSH_ST_Z        2
`define RSH_ST_PD_N     3
`define RSH_ST_TO_N     4
`define RSH_ST_SLEEP    5
`define RSH_CMD_LIT_LO  0
`define RSH_CMD_LIT_HI  7
`define RSH_CMD_F_LO    8
`define RSH_CMD_F_HI    14
`define RSH_CMD_DEST    15
`define RSH_CMD_OP_LO   16
`define RSH_CMD_OP_HI   18
`define RSH_RST_ACC     8'h00
`define RSH_RST_FLAGS   3'h0
`define RSH_WDOG_PRE    8
`define RSH_WDOG_W      8
`endif

//--- rsh_exec.sv
// Rotate, subtract and halt execution datapath with a Wishbone register port
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rsh_defines.svh"

module rsh_exec #(
    parameter int FILE_DEPTH = 128,
    parameter int WDOG_PRE   = `RSH_WDOG_PRE
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Wake pin and power control
    input  wire logic        wake_i,
    output logic             sleep_o,
    output logic             osc_en_o
);
    import rsh_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]           acc_q, acc_d;            // Accumulator
    logic                 c_q, c_d;                // Carry
    logic                 dc_q, dc_d;              // Nibble carry, low on borrow
    logic                 z_q, z_d;                // Zero
    logic                 pd_n_q, pd_n_d;          // Halt entered flag, low
    logic                 to_n_q, to_n_d;          // Expiry flag, low
    rsh_state_type        st_q, st_d;              // Run or sleep
    logic [6:0]           faddr_q, faddr_d;        // File window index
    logic [7:0]           file_q [FILE_DEPTH];     // File registers
    logic                 fwe;                     // File write enable
    logic [6:0]           fwa;                     // File write index
    logic [7:0]           fwd;                     // File write data
    logic [7:0]           pre_q, pre_d;            // Watchdog prescaler
    logic [7:0]           wdog_q, wdog_d;          // Watchdog counter
    logic                 ack_q, ack_d;            // Bus answer
    logic [31:0]          dat_q, dat_d;            // Bus read data
    logic                 osc_q, osc_d;            // Oscillator enable
    logic [1:0]           wake_s;                  // Wake synchroniser

    ////////////////////////////////////////////////////////////////////
    // Decode of a committed bus write
    logic       wr;                                // Write commits now
    logic       cmd_go;                            // Command write
    rsh_op_type op;                                // Decoded operation
    logic [7:0] lit;                               // Literal operand
    logic [6:0] fsel;                              // File operand index
    logic       dest;                              // Destination select
    logic [7:0] fval;                              // File operand value

    // A write takes effect only in the cycle that carries the answer,
    // so a request held past its answer is applied again every second cycle
    assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign cmd_go = wr && (wb_adr_i == `RSH_OFS_CMD) && st_q == RSH_RUN;
    assign op     = rsh_op_type'(wb_dat_i[`RSH_CMD_OP_HI:`RSH_CMD_OP_LO]);
    assign lit    = wb_dat_i[`RSH_CMD_LIT_HI:`RSH_CMD_LIT_LO];
    assign fsel   = wb_dat_i[`RSH_CMD_F_HI:`RSH_CMD_F_LO];
    assign dest   = wb_dat_i[`RSH_CMD_DEST];
    // An index past the file reads as zero rather than an unknown
    assign fval   = (int'(fsel) < FILE_DEPTH) ? file_q[fsel] : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Subtractor shared by the three subtract forms
    logic [7:0] min_v;                             // Minuend
    logic       brw;                               // Borrow in
    logic [8:0] diff;                              // Full difference
    logic [4:0] ndiff;                             // Low nibble difference

    always_comb begin
        // Literal form takes the literal, the others the file
        min_v = (op == RSH_OP_LIT_SUB) ? lit : fval;
        // Borrow in is the inverted carry, only with borrow form
        brw   = (op == RSH_OP_REG_SUB_BRW) && !c_q;
        // One extra bit on each operand: the top bit of the difference is
        // the borrow out, and its inverse is the carry
        diff  = {1'b0, min_v} - {1'b0, acc_q} - {8'h00, brw};
        ndiff = {1'b0, min_v[3:0]} - {1'b0, acc_q[3:0]} - {4'h0, brw};
    end

    ////////////////////////////////////////////////////////////////////
    // Datapath next values
    logic [7:0] res;                               // Operation result
    logic       res_wr;                            // Result produced
    logic       to_acc;                            // Result to accumulator

    always_comb begin
        acc_d   = acc_q;
        c_d     = c_q;
        dc_d    = dc_q;
        z_d     = z_q;
        pd_n_d  = pd_n_q;
        to_n_d  = to_n_q;
        st_d    = st_q;
        osc_d   = osc_q;
        faddr_d = faddr_q;
        pre_d   = pre_q;
        wdog_d  = wdog_q;
        res     = 8'h00;
        res_wr  = 1'b0;
        to_acc  = 1'b0;
        fwe     = 1'b0;
        fwa     = faddr_q;
        fwd     = wb_dat_i[7:0];
        // Watchdog keeps running, also in sleep
        // The prescaler is the divider: its terminal count is a one-cycle
        // tick that advances the counter, so no second clock is needed
        if (pre_q == 8'(WDOG_PRE - 1)) begin
            pre_d  = 8'h00;
            wdog_d = wdog_q + 8'h01;
            // Wrap is an expiry: flag it and wake the core
            if (wdog_q == 8'hFF) begin
                to_n_d = 1'b0;
                st_d   = RSH_RUN;
                osc_d  = 1'b1;
            end
        end else begin
            pre_d = pre_q + 8'h01;
        end
        // Wake pin ends sleep
        if (st_q == RSH_SLEEP && wake_s[1]) begin
            st_d  = RSH_RUN;
            osc_d = 1'b1;
        end
        // Plain register writes
        if (wr) begin
            case (wb_adr_i)
                `RSH_OFS_ACC: begin
                    if (wb_sel_i[0]) acc_d = wb_dat_i[7:0];
                end
                `RSH_OFS_STATUS: begin
                    if (wb_sel_i[0]) begin
                        c_d  = wb_dat_i[`RSH_ST_C];
                        dc_d = wb_dat_i[`RSH_ST_DC];
                        z_d  = wb_dat_i[`RSH_ST_Z];
                    end
                end
                `RSH_OFS_FADDR: begin
                    if (wb_sel_i[0]) faddr_d = wb_dat_i[6:0];
                end
                `RSH_OFS_FDATA: begin
                    fwe = wb_sel_i[0];
                end
                default: begin
                    // Unmapped, command or watchdog: no plain store
                end
            endcase
        end
        // Command execution
        // A command written in sleep is dropped: the core stays halted until
        // the wake pin or an expiry lets it run again
        if (cmd_go) begin
            case (op)
                RSH_OP_ROT_RIGHT: begin
                    res    = {c_q, fval[7:1]};
                    c_d    = fval[0];
                    res_wr = 1'b1;
                    to_acc = !dest;
                end
                RSH_OP_ROT_LEFT: begin
                    res    = {fval[6:0], c_q};
                    c_d    = fval[7];
                    res_wr = 1'b1;
                    to_acc = !dest;
                end
                RSH_OP_LIT_SUB: begin
                    res    = diff[7:0];
                    res_wr = 1'b1;
                    to_acc = 1'b1;
                end
                RSH_OP_REG_SUB, RSH_OP_REG_SUB_BRW: begin
                    res    = diff[7:0];
                    res_wr = 1'b1;
                    to_acc = !dest;
                end
                RSH_OP_HALT: begin
                    // Placed after the watchdog update, so halt wins over an
                    // expiry in the same cycle: it clears that counter too
                    pd_n_d = 1'b0;
                    to_n_d = 1'b1;
                    wdog_d = 8'h00;
                    pre_d  = 8'h00;
                    st_d   = RSH_SLEEP;
                    osc_d  = 1'b0;
                end
                default: begin
                    // No operation
                end
            endcase
            // Flags of every subtract form
            if (op == RSH_OP_LIT_SUB || op == RSH_OP_REG_SUB
                || op == RSH_OP_REG_SUB_BRW) begin
                c_d  = !diff[8];
                dc_d = !ndiff[4];
                z_d  = (diff[7:0] == 8'h00);
            end
            // Result routing by destination select
            // Literal subtract forces the accumulator and never touches the file
            if (res_wr) begin
                if (to_acc) begin
                    acc_d = res;
                end else begin
                    fwe = 1'b1;
                    fwa = fsel;
                    fwd = res;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus answer and read data next values
    // The answer follows a request by one cycle and is then withheld for
    // one cycle, so a strobe held too long is never answered twice in a row.
    // Read data is captured with the answer and reads zero otherwise
    always_comb begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        dat_d = 32'h0000_0000;
        if (ack_d && !wb_we_i) begin
            case (wb_adr_i)
                `RSH_OFS_ACC:    dat_d = {24'h00_0000, acc_q};
                `RSH_OFS_STATUS: dat_d = {26'h0, st_q == RSH_SLEEP,
                                          to_n_q, pd_n_q, z_q, dc_q, c_q};
                `RSH_OFS_FADDR:  dat_d = {25'h0, faddr_q};
                `RSH_OFS_FDATA:  dat_d = {24'h00_0000,
                    (int'(faddr_q) < FILE_DEPTH) ? file_q[faddr_q] : 8'h00};
                `RSH_OFS_WDOG:   dat_d = {16'h0000, pre_q, wdog_q};
                default:         dat_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        // The wake synchroniser runs through reset, so the pin has settled
        // by the time the core is released
        wake_s <= {wake_s[0], wake_i};
        if (rst_i) begin
            acc_q   <= `RSH_RST_ACC;
            {z_q, dc_q, c_q} <= `RSH_RST_FLAGS;
            pd_n_q  <= 1'b1;
            to_n_q  <= 1'b1;
            st_q    <= RSH_RUN;
            osc_q   <= 1'b1;
            faddr_q <= 7'h00;
            pre_q   <= 8'h00;
            wdog_q  <= 8'h00;
            ack_q   <= 1'b0;
            dat_q   <= 32'h0000_0000;
        end else begin
            acc_q   <= acc_d;
            c_q     <= c_d;
            dc_q    <= dc_d;
            z_q     <= z_d;
            pd_n_q  <= pd_n_d;
            to_n_q  <= to_n_d;
            st_q    <= st_d;
            osc_q   <= osc_d;
            faddr_q <= faddr_d;
            pre_q   <= pre_d;
            wdog_q  <= wdog_d;
            ack_q   <= ack_d;
            dat_q   <= dat_d;
        end
    end

    // File registers, one entry written per cycle
    // No reset here: software writes an entry before it reads it
    always_ff @(posedge clk_i) begin
        if (fwe && int'(fwa) < FILE_DEPTH) begin
            file_q[fwa] <= fwd;
        end
    end

    // Outputs straight from flip-flops
    // Sleep and oscillator enable leave from flops, so the clock
    // controller never sees a glitch while the next state settles
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign sleep_o  = (st_q == RSH_SLEEP);
    assign osc_en_o = osc_q;
endmodule
`default_nettype wire

//--- rsh_exec_props.sv
// Port checker of the rotate, subtract and halt datapath
`timescale 1ns/1ps
`default_nettype none
module rsh_exec_chk #(
    parameter int FILE_DEPTH = 128,
    parameter int WDOG_PRE   = 8
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Power pins
    input wire logic        wake_i,
    input wire logic        sleep_o,
    input wire logic        osc_en_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Halt command taken in this cycle
    wire logic halt_wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == 5'h08) & (wb_dat_i[18:16] == 3'h6);
    // Status read answered in this cycle
    wire logic st_rd   = wb_ack_o & ~wb_we_i & (wb_adr_i == 5'h04);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    halt_sleep_a: assert property (halt_wr && !sleep_o |=> sleep_o && !osc_en_o)
        else $error("halt did not stop the oscillator");
    osc_off_a: assert property (sleep_o |-> !osc_en_o)
        else $error("oscillator running in sleep");
    sleep_cause_a: assert property ($rose(sleep_o) |-> $past(halt_wr))
        else $error("sleep entered without halt");
    halt_flags_a: assert property (st_rd && $past(sleep_o) |-> wb_dat_o[5] && !wb_dat_o[3])
        else $error("sleep or power-down status wrong");
    wake_exit_a: assert property (sleep_o && wake_i ##1 wake_i [*3] |=> !sleep_o)
        else $error("wake pin did not end sleep");
    reset_state_a: assert property ($past(rst_i) |-> !wb_ack_o && !sleep_o && osc_en_o)
        else $error("outputs wrong after reset");
endmodule
bind rsh_exec rsh_exec_chk #(.FILE_DEPTH(FILE_DEPTH), .WDOG_PRE(WDOG_PRE)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wake_i(wake_i), .sleep_o(sleep_o), .osc_en_o(osc_en_o)
);
`default_nettype wire

//--- rsh_exec_tb_top.sv
// Self-checking bench of the rotate, subtract and halt datapath
`timescale 1ns/1ps
`default_nettype none
module rsh_exec_tb_top;
    ////////////////////////////////////////////////////////////////////////////////
    // Design pins
    logic        clk, rst, cyc, stb, we, wake, ack, slp, osc, b;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dw, dr;
    // Expected read words and masks, oldest first
    logic [31:0] exp_q[$], msk_q[$];
    // Bench model of the datapath
    logic [7:0]  acc, f, lit, r, m;
    logic        c, dc, z, dst;
    logic [2:0]  op;
    logic [6:0]  idx;
    integer      seed = 23, mismatches = 0, num_checks = 0, i, n;
    rsh_exec #(.WDOG_PRE(16)) dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wake_i(wake),
        .sleep_o(slp), .osc_en_o(osc)
    );
    // Clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input logic [4:0] a);
        num_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD reg %h exp %h seen %h", a, want, seen);
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One classic Wishbone cycle, waiting for ack
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dw  <= d;
        sel <= s;
        // Wait as long as the answer takes; the hang guard ends a stuck bus
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // Read with a noted expectation
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] k);
        exp_q.push_back(e & k);
        msk_q.push_back(k);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    // Status word from the model flags
    function automatic logic [31:0] st(input logic s, input logic to_n, input logic pd_n);
        return {26'h0, s, to_n, pd_n, z, dc, c};
    endfunction
    // Watcher of read answers
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            check(dr & msk_q.pop_front(), exp_q.pop_front(), adr);
        end
    end
    // Hang guard
    initial begin
        #100000;
        mismatches++;
        results();
    end
    // Main sequence
    initial begin
        {rst, cyc, stb, we, wake, adr, sel, dw, c, dc, z} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(5'h04, st(1'b0, 1'b1, 1'b1), '1);
        bus(1'b1, 5'h18, 32'hFF, 4'hF);
        rd(5'h18, 32'h0, '1);
        bus(1'b1, 5'h00, 32'h5A, 4'h0);
        rd(5'h00, 32'h0, '1);
        for (i = 0; i < 60; i++) begin
            n = $random(seed);
            {dst, idx, lit, acc, f} = n;
            n = $random(seed);
            {c, dc, z} = n[2:0];
            op = 3'(n[7:3] % 6);
            if (n[8]) begin
                acc = f;
                lit = f;
            end
            bus(1'b1, 5'h00, {24'h0, acc}, 4'h1);
            bus(1'b1, 5'h04, {29'h0, z, dc, c}, 4'h1);
            bus(1'b1, 5'h0C, {25'h0, idx}, 4'h1);
            bus(1'b1, 5'h10, {24'h0, f}, 4'h1);
            bus(1'b1, 5'h08, {13'h0, op, dst, idx, lit}, 4'hF);
            b = (op == 3'h5) ? !c : 1'b0;
            m = (op == 3'h3) ? lit : f;
            case (op)
                3'h0: r = dst ? f : acc;
                3'h1: {r, c} = {c, f};
                3'h2: {c, r} = {f, c};
                default: begin
                    r = m - acc - 8'(b);
                    c = ({1'b0, m} >= {1'b0, acc} + 9'(b));
                    dc = ({1'b0, m[3:0]} >= {1'b0, acc[3:0]} + 5'(b));
                    z = (r == 8'h0);
                end
            endcase
            if (dst && op != 3'h3) f = r;
            else acc = r;
            rd(5'h00, {24'h0, acc}, '1);
            rd(5'h04, st(1'b0, 1'b1, 1'b1), '1);
            rd(5'h10, {24'h0, f}, '1);
        end
        bus(1'b1, 5'h08, 32'h0006_0000, 4'hF);
        rd(5'h04, st(1'b1, 1'b1, 1'b0), '1);
        // Counter cleared, prescaler has counted four cycles since the halt
        rd(5'h14, 32'h0000_0400, '1);
        bus(1'b1, 5'h08, 32'h0003_0077, 4'hF);
        rd(5'h00, {24'h0, acc}, '1);
        check({30'h0, slp, osc}, 32'h2, 5'h1F);
        n = 0;
        while (slp !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n > 4000 && n < 5000}, 32'h1, 5'h14);
        rd(5'h04, st(1'b0, 1'b0, 1'b0), '1);
        bus(1'b1, 5'h08, 32'h0006_0000, 4'hF);
        wake <= 1'b1;
        repeat (6) @(posedge clk);
        wake <= 1'b0;
        check({30'h0, slp, osc}, 32'h1, 5'h1F);
        rd(5'h04, st(1'b0, 1'b1, 1'b0), '1);
        rst <= 1'b1;
        {c, dc, z} = 3'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(5'h04, st(1'b0, 1'b1, 1'b1), '1);
        results();
    end
endmodule
`default_nettype wire

//--- rsh_pkg.sv
// Types shared by the execution datapath
package rsh_pkg;
    // Operation codes written to the command register
    typedef enum logic [2:0] {
        RSH_OP_NOP,
        RSH_OP_ROT_RIGHT,
        RSH_OP_ROT_LEFT,
        RSH_OP_LIT_SUB,
        RSH_OP_REG_SUB,
        RSH_OP_REG_SUB_BRW,
        RSH_OP_HALT
    } rsh_op_type;
    // Core run state
    typedef enum logic {
        RSH_RUN,
        RSH_SLEEP
    } rsh_state_type;
endpackage
